// File: core/bbx_data_ram.sv
// Purpose: Data memory of the executor, one write port, registered read
// Assumes: Single clock, read data valid one cycle after the address
// Notes: Array contents are not reset
module bbx_data_ram #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule : bbx_data_ram

// File: core/bbx_exec.sv
// Purpose: Executes bit, branch, table-read and miscellaneous instructions issued over APB
// Assumes: Program words arrive on prog_word one cycle after prog_addr, same clock
// Notes: One wait state on every APB transfer; instruction writes while busy are refused
// Summary of operation
// - Bit clear and bit set force one memory bit; one cycle, flags untouched.
// - Unconditional jump loads the target into the counter; two cycles, no flags.
// - Skip-if-zero skips when the byte is zero; variant also copies it to work.
// - Bit-test skips on the selected bit being zero, or being one.
// - Increment or decrement skip writes the new byte back, skips when it is zero.
// - Work variants put the new value in work, memory untouched, skip on zero.
// - Call, exit, exit with immediate and interrupt exit take two cycles, no flags.
// - Table reads fetch current or last page word into latch and memory; two cycles.
// - Only watchdog clear, pre-clears, power-down and watchdog overflow change timeout and power-down flags here.
// - Pre-clears clear both flags only as a consecutive pair, otherwise flags hold.
// - Nibble swap exchanges byte halves in one cycle; variant writes work instead.
// - Power-down instruction enters power-down and updates both flags.
// - Skip instructions take two cycles when skipping, one otherwise.
// - Any instruction writing the counter low byte takes two cycles.
// - Watchdog clear resets the watchdog counter and clears both flags.
// - Power-down stops execution, keeps state, clears watchdog, sets power-down flag.
//
// The implementer's own choices: the APB register port and the address map.
`include "bbx_map.svh"

module bbx_exec #(
    parameter logic [15:0] WDT_LIMIT = `BBX_WDT_CYCLES,
    parameter int MEM_DEPTH = 128
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [10:0] prog_addr,
    input wire logic [14:0] prog_word,
    output logic powered_down,
    output logic timeout_flag,
    output logic powerdown_flag
);
    bbx_pkg::bbx_regs_t r;
    bbx_pkg::bbx_regs_t n;

    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    bbx_data_ram #(
        .DEPTH(MEM_DEPTH),
        .AW(7),
        .DW(8)
    ) u_ram (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    always_comb begin
        logic busy;
        logic win;
        logic err;
        logic [31:0] rd_val;
        logic wr_fire;
        bbx_pkg::bbx_op_t op;
        bbx_pkg::bbx_op_t new_op;
        logic [2:0] bsel;
        logic [6:0] maddr;
        logic [10:0] tgt;
        logic [7:0] mask;
        logic [7:0] m;
        logic [7:0] res;
        logic do_wr;
        logic skip;
        logic two;
        logic [10:0] pc_n;
        logic [1:0] sp_m1;

        n = r;
        busy = r.state inside {bbx_pkg::ST_READ, bbx_pkg::ST_EXEC, bbx_pkg::ST_DUMMY};
        win = paddr[11:9] == `BBX_WIN_SEL;
        op = bbx_pkg::bbx_op_t'(r.instr[`BBX_F_OP_HI:`BBX_F_OP_LO]);
        new_op = bbx_pkg::bbx_op_t'(pwdata[`BBX_F_OP_HI:`BBX_F_OP_LO]);
        bsel = r.instr[`BBX_F_BIT_HI:`BBX_F_BIT_LO];
        maddr = r.instr[`BBX_F_MADDR_HI:`BBX_F_MADDR_LO];
        tgt = r.instr[`BBX_F_TGT_HI:`BBX_F_TGT_LO];
        mask = 8'(8'h01 << bsel);
        m = (maddr == `BBX_PCL_ADDR) ? r.pc[7:0] : mem_rdata;
        res = 8'h00;
        do_wr = 1'b0;
        skip = 1'b0;
        two = 1'b0;
        pc_n = r.pc + 11'h001;
        sp_m1 = r.sp - 2'h1;
        wr_fire = psel && penable && pwrite && r.pready && !r.pslverr;

        // Core owns the memory port while an instruction runs
        mem_we = 1'b0;
        mem_addr = busy ? maddr : paddr[8:2];
        mem_wdata = 8'h00;

        // Register decode and refusal of accesses that would disturb a running instruction
        rd_val = 32'h0000_0000;
        err = 1'b0;
        if (win) begin
            err = busy;
            rd_val = {24'h00_0000, mem_rdata};
        end else begin
            unique case (paddr)
                `BBX_OFF_CTRL: rd_val = {30'h0000_0000, r.int_en, 1'b0};
                `BBX_OFF_INSTR: begin
                    rd_val = r.instr;
                    err = pwrite && (busy || r.state == bbx_pkg::ST_HALTED);
                end
                `BBX_OFF_STATUS: begin
                    rd_val = {22'h00_0000, r.pre, 1'b0, r.cycles, r.annul,
                        r.powerdown, r.timeout, r.state == bbx_pkg::ST_HALTED, busy};
                    err = pwrite;
                end
                `BBX_OFF_WORK: begin
                    rd_val = {24'h00_0000, r.work};
                    err = pwrite && busy;
                end
                `BBX_OFF_PC: begin
                    rd_val = {21'h00_0000, r.pc};
                    err = pwrite && busy;
                end
                `BBX_OFF_TABLE: begin
                    rd_val = {16'h0000, r.tptr, 1'b0, r.table_high_latch};
                    err = pwrite && busy;
                end
                default: err = 1'b1;
            endcase
        end

        // One wait state: data and pready are captured in the first access cycle
        if (psel && !penable && !r.pready) begin
            n.apb_wait = 1'b1;
        end else if (psel && penable && r.apb_wait) begin
            n.apb_wait = 1'b0;
            n.pready = 1'b1;
            n.pslverr = err;
            n.prdata = (err || pwrite) ? 32'h0000_0000 : rd_val;
        end else if (r.pready) begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end

        // Software writes take effect only at the edge that completes the transfer
        if (wr_fire) begin
            if (win) begin
                mem_we = 1'b1;
                mem_wdata = pwdata[7:0];
            end else begin
                unique case (paddr)
                    `BBX_OFF_CTRL: begin
                        n.int_en = pwdata[`BBX_F_CTRL_INTEN];
                        if (pwdata[`BBX_F_CTRL_WAKE] && r.state == bbx_pkg::ST_HALTED) begin
                            n.state = bbx_pkg::ST_IDLE;
                        end
                    end
                    `BBX_OFF_INSTR: begin
                        if (r.annul) begin
                            n.annul = 1'b0;
                        end else begin
                            n.instr = pwdata;
                            n.state = bbx_pkg::ST_READ;
                            if (new_op == bbx_pkg::OP_TABLE_READ_LAST_PAGE) begin
                                n.prog_addr = {`BBX_LAST_PAGE, r.tptr};
                            end else begin
                                n.prog_addr = {r.pc[10:8], r.tptr};
                            end
                        end
                    end
                    `BBX_OFF_WORK: n.work = pwdata[7:0];
                    `BBX_OFF_PC: n.pc = pwdata[10:0];
                    `BBX_OFF_TABLE: n.tptr = pwdata[15:8];
                    default: n.tptr = r.tptr;
                endcase
            end
        end

        n.wdt = r.wdt + 16'h0001;

        unique case (r.state)
            bbx_pkg::ST_IDLE, bbx_pkg::ST_HALTED: begin
            end
            bbx_pkg::ST_READ: n.state = bbx_pkg::ST_EXEC;
            bbx_pkg::ST_DUMMY: n.state = bbx_pkg::ST_IDLE;
            bbx_pkg::ST_EXEC: begin
                n.pre = bbx_pkg::PRE_NONE;
                unique case (op)
                    bbx_pkg::OP_BIT_CLEAR: begin
                        res = m & ~mask;
                        do_wr = 1'b1;
                    end
                    bbx_pkg::OP_BIT_SET: begin
                        res = m | mask;
                        do_wr = 1'b1;
                    end
                    bbx_pkg::OP_UNCONDITIONAL_JUMP: begin
                        pc_n = tgt;
                        two = 1'b1;
                    end
                    bbx_pkg::OP_SKIP_IF_ZERO: skip = m == 8'h00;
                    bbx_pkg::OP_SKIP_IF_ZERO_COPY_TO_WORK: begin
                        skip = m == 8'h00;
                        n.work = m;
                    end
                    bbx_pkg::OP_SKIP_IF_BIT_CLEAR: skip = (m & mask) == 8'h00;
                    bbx_pkg::OP_SKIP_IF_BIT_SET: skip = (m & mask) != 8'h00;
                    bbx_pkg::OP_INCREMENT_SKIP_IF_ZERO: begin
                        res = m + 8'h01;
                        do_wr = 1'b1;
                        skip = res == 8'h00;
                    end
                    bbx_pkg::OP_DECREMENT_SKIP_IF_ZERO: begin
                        res = m - 8'h01;
                        do_wr = 1'b1;
                        skip = res == 8'h00;
                    end
                    bbx_pkg::OP_INCREMENT_SKIP_TO_WORK: begin
                        n.work = m + 8'h01;
                        skip = n.work == 8'h00;
                    end
                    bbx_pkg::OP_DECREMENT_SKIP_TO_WORK: begin
                        n.work = m - 8'h01;
                        skip = n.work == 8'h00;
                    end
                    bbx_pkg::OP_SUBROUTINE_CALL: begin
                        n.stack[r.sp] = r.pc + 11'h001;
                        n.sp = r.sp + 2'h1;
                        pc_n = tgt;
                        two = 1'b1;
                    end
                    bbx_pkg::OP_SUBROUTINE_EXIT, bbx_pkg::OP_SUBROUTINE_EXIT_IMM,
                    bbx_pkg::OP_INTERRUPT_EXIT: begin
                        n.sp = sp_m1;
                        pc_n = r.stack[sp_m1];
                        two = 1'b1;
                        if (op == bbx_pkg::OP_SUBROUTINE_EXIT_IMM) begin
                            n.work = tgt[7:0];
                        end
                        if (op == bbx_pkg::OP_INTERRUPT_EXIT) begin
                            n.int_en = 1'b1;
                        end
                    end
                    bbx_pkg::OP_TABLE_READ_CURRENT_PAGE, bbx_pkg::OP_TABLE_READ_LAST_PAGE: begin
                        n.table_high_latch = prog_word[14:8];
                        res = prog_word[7:0];
                        do_wr = 1'b1;
                        two = 1'b1;
                    end
                    bbx_pkg::OP_WATCHDOG_CLEAR: begin
                        n.wdt = 16'h0000;
                        n.timeout = 1'b0;
                        n.powerdown = 1'b0;
                    end
                    bbx_pkg::OP_WATCHDOG_PRECLEAR_FIRST, bbx_pkg::OP_WATCHDOG_PRECLEAR_SECOND: begin
                        if ((op == bbx_pkg::OP_WATCHDOG_PRECLEAR_FIRST && r.pre == bbx_pkg::PRE_SECOND)
                            || (op == bbx_pkg::OP_WATCHDOG_PRECLEAR_SECOND
                            && r.pre == bbx_pkg::PRE_FIRST)) begin
                            n.wdt = 16'h0000;
                            n.timeout = 1'b0;
                            n.powerdown = 1'b0;
                        end else if (op == bbx_pkg::OP_WATCHDOG_PRECLEAR_FIRST) begin
                            n.pre = bbx_pkg::PRE_FIRST;
                        end else begin
                            n.pre = bbx_pkg::PRE_SECOND;
                        end
                    end
                    bbx_pkg::OP_MEM_CLEAR: begin
                        res = 8'h00;
                        do_wr = 1'b1;
                    end
                    bbx_pkg::OP_MEM_SET: begin
                        res = 8'hff;
                        do_wr = 1'b1;
                    end
                    bbx_pkg::OP_NIBBLE_SWAP: begin
                        res = {m[3:0], m[7:4]};
                        do_wr = 1'b1;
                    end
                    bbx_pkg::OP_NIBBLE_SWAP_TO_WORK: n.work = {m[3:0], m[7:4]};
                    bbx_pkg::OP_POWER_DOWN: begin
                        n.wdt = 16'h0000;
                        n.timeout = 1'b0;
                        n.powerdown = 1'b1;
                    end
                    default: pc_n = r.pc + 11'h001;
                endcase

                if (do_wr) begin
                    if (maddr == `BBX_PCL_ADDR) begin
                        pc_n = {r.pc[10:8], res};
                        two = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_wdata = res;
                    end
                end
                if (skip) begin
                    pc_n = r.pc + 11'h002;
                    n.annul = 1'b1;
                    two = 1'b1;
                end
                n.pc = pc_n;
                n.cycles = two ? `BBX_TWO_CYCLES : `BBX_ONE_CYCLE;
                if (op == bbx_pkg::OP_POWER_DOWN) begin
                    n.state = bbx_pkg::ST_HALTED;
                end else if (two) begin
                    n.state = bbx_pkg::ST_DUMMY;
                end else begin
                    n.state = bbx_pkg::ST_IDLE;
                end
            end
            default: n.state = bbx_pkg::ST_IDLE;
        endcase

        // Watchdog overflow sets the timeout flag after any clear, so the set wins
        if (r.wdt == WDT_LIMIT - 16'h0001) begin
            n.wdt = 16'h0000;
            n.timeout = 1'b1;
            if (r.state == bbx_pkg::ST_HALTED) begin
                n.state = bbx_pkg::ST_IDLE;
            end
        end
        n.halted = n.state == bbx_pkg::ST_HALTED;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{
                state: bbx_pkg::ST_IDLE,
                halted: 1'b0,
                instr: 32'h0000_0000,
                pc: `BBX_RST_PC,
                work: `BBX_RST_WORK,
                table_high_latch: `BBX_RST_TABLE_HIGH_LATCH,
                tptr: `BBX_RST_TPTR,
                stack: '0,
                sp: 2'h0,
                timeout: 1'b0,
                powerdown: 1'b0,
                annul: 1'b0,
                int_en: 1'b0,
                pre: bbx_pkg::PRE_NONE,
                cycles: 2'h0,
                wdt: 16'h0000,
                prog_addr: 11'h000,
                apb_wait: 1'b0,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h0000_0000
            };
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign prog_addr = r.prog_addr;
    assign powered_down = r.halted;
    assign timeout_flag = r.timeout;
    assign powerdown_flag = r.powerdown;
endmodule : bbx_exec

// File: include/bbx_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the executor
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Data memory window sits at 0x200..0x3fc, one byte per word
`ifndef BBX_MAP_SVH
`define BBX_MAP_SVH

`define BBX_OFF_CTRL 12'h000
`define BBX_OFF_INSTR 12'h004
`define BBX_OFF_STATUS 12'h008
`define BBX_OFF_WORK 12'h00c
`define BBX_OFF_PC 12'h010
`define BBX_OFF_TABLE 12'h014
`define BBX_WIN_SEL 3'h1

`define BBX_F_OP_HI 4
`define BBX_F_OP_LO 0
`define BBX_F_BIT_HI 7
`define BBX_F_BIT_LO 5
`define BBX_F_MADDR_HI 14
`define BBX_F_MADDR_LO 8
`define BBX_F_TGT_HI 26
`define BBX_F_TGT_LO 16
`define BBX_F_CTRL_WAKE 0
`define BBX_F_CTRL_INTEN 1

`define BBX_RST_PC 11'h000
`define BBX_RST_WORK 8'h00
`define BBX_RST_TPTR 8'h00
`define BBX_RST_TABLE_HIGH_LATCH 7'h00
`define BBX_PCL_ADDR 7'h06
`define BBX_LAST_PAGE 3'h7

`define BBX_ONE_CYCLE 2'h1
`define BBX_TWO_CYCLES 2'h2
`define BBX_WDT_CYCLES 16'h2000

`endif

// File: include/bbx_pkg.sv
// Purpose: Types shared by the instruction executor
// Assumes: 8-bit data path, 11-bit program counter, 15-bit program words
// Notes: Unlisted opcodes execute as no operation
package bbx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_READ = 3'h1,
        ST_EXEC = 3'h2,
        ST_DUMMY = 3'h3,
        ST_HALTED = 3'h4
    } bbx_state_t;

    typedef enum logic [1:0] {
        PRE_NONE = 2'h0,
        PRE_FIRST = 2'h1,
        PRE_SECOND = 2'h2
    } bbx_pre_t;

    typedef enum logic [4:0] {
        OP_NO_OPERATION = 5'h00,
        OP_BIT_CLEAR = 5'h01,
        OP_BIT_SET = 5'h02,
        OP_UNCONDITIONAL_JUMP = 5'h03,
        OP_SKIP_IF_ZERO = 5'h04,
        OP_SKIP_IF_ZERO_COPY_TO_WORK = 5'h05,
        OP_SKIP_IF_BIT_CLEAR = 5'h06,
        OP_SKIP_IF_BIT_SET = 5'h07,
        OP_INCREMENT_SKIP_IF_ZERO = 5'h08,
        OP_DECREMENT_SKIP_IF_ZERO = 5'h09,
        OP_INCREMENT_SKIP_TO_WORK = 5'h0a,
        OP_DECREMENT_SKIP_TO_WORK = 5'h0b,
        OP_SUBROUTINE_CALL = 5'h0c,
        OP_SUBROUTINE_EXIT = 5'h0d,
        OP_SUBROUTINE_EXIT_IMM = 5'h0e,
        OP_INTERRUPT_EXIT = 5'h0f,
        OP_TABLE_READ_CURRENT_PAGE = 5'h10,
        OP_TABLE_READ_LAST_PAGE = 5'h11,
        OP_WATCHDOG_CLEAR = 5'h12,
        OP_WATCHDOG_PRECLEAR_FIRST = 5'h13,
        OP_WATCHDOG_PRECLEAR_SECOND = 5'h14,
        OP_MEM_CLEAR = 5'h15,
        OP_MEM_SET = 5'h16,
        OP_NIBBLE_SWAP = 5'h17,
        OP_NIBBLE_SWAP_TO_WORK = 5'h18,
        OP_POWER_DOWN = 5'h19
    } bbx_op_t;

    typedef struct packed {
        bbx_state_t state;
        logic halted;
        logic [31:0] instr;
        logic [10:0] pc;
        logic [7:0] work;
        logic [6:0] table_high_latch;
        logic [7:0] tptr;
        logic [3:0][10:0] stack;
        logic [1:0] sp;
        logic timeout;
        logic powerdown;
        logic annul;
        logic int_en;
        bbx_pre_t pre;
        logic [1:0] cycles;
        logic [15:0] wdt;
        logic [10:0] prog_addr;
        logic apb_wait;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bbx_regs_t;

endpackage : bbx_pkg

// File: tb/bbx_exec_checker.sv
// Purpose: Bus timing and flag checks for the instruction executor
// Assumes: Sees the top module ports only
// Notes: Bound into every bbx_exec instance
module bbx_exec_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [10:0] prog_addr,
    input wire logic powered_down,
    input wire logic timeout_flag,
    input wire logic powerdown_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic setup;
    assign setup = psel && !penable;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    answer_wait_a: assert property (setup && !pready |=> !pready ##1 pready)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (setup && (paddr == 12'h018 || (pwrite && paddr == 12'h008))
        |-> ##2 pready && pslverr)
        else $error("refused access not flagged");
    refused_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    prog_addr_hold_a: assert property (!$stable(prog_addr) |->
        $past(pready && pwrite && paddr == 12'h004))
        else $error("program address moved without instruction");
    halt_flags_a: assert property ($rose(powered_down) |->
        powerdown_flag && !timeout_flag)
        else $error("power-down flags wrong");
    pdf_source_a: assert property ($rose(powerdown_flag) |-> powered_down)
        else $error("power-down flag set while running");
    pdf_clear_a: assert property ($fell(powerdown_flag) |-> !$past(powered_down))
        else $error("power-down flag cleared while halted");
    wake_cause_a: assert property ($fell(powered_down) |->
        $past(pready && pwrite && paddr == 12'h000) || timeout_flag)
        else $error("left power-down without cause");
    cover property (pready && pslverr);
    cover property ($rose(powered_down));
    cover property ($fell(timeout_flag));
endmodule : bbx_exec_checker

bind bbx_exec bbx_exec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .powered_down(powered_down),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

// File: tb/bbx_exec_tb.sv
// Purpose: Directed test of the instruction executor over APB
// Assumes: Watchdog shortened to 512 cycles
// Notes: Program memory answers one cycle after its address
module bbx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [10:0] prog_addr;
    logic [14:0] prog_word = 15'h0;
    logic powered_down;
    logic timeout_flag;
    logic powerdown_flag;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;
    localparam logic [32:0] SK [12] = '{
        {5'h04, 3'h0, 8'h00, 8'h00, 8'haa, 1'b1}, {5'h04, 3'h0, 8'h05, 8'h05, 8'haa, 1'b0},
        {5'h05, 3'h0, 8'h00, 8'h00, 8'h00, 1'b1}, {5'h05, 3'h0, 8'h07, 8'h07, 8'h07, 1'b0},
        {5'h06, 3'h3, 8'h08, 8'h08, 8'haa, 1'b0}, {5'h06, 3'h4, 8'h08, 8'h08, 8'haa, 1'b1},
        {5'h07, 3'h3, 8'h08, 8'h08, 8'haa, 1'b1}, {5'h08, 3'h0, 8'hff, 8'h00, 8'haa, 1'b1},
        {5'h08, 3'h0, 8'h10, 8'h11, 8'haa, 1'b0}, {5'h09, 3'h0, 8'h01, 8'h00, 8'haa, 1'b1},
        {5'h0a, 3'h0, 8'h05, 8'h05, 8'h06, 1'b0}, {5'h0b, 3'h0, 8'h01, 8'h01, 8'h00, 1'b1}};

    bbx_exec #(.WDT_LIMIT(16'h0200)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_word(prog_word),
        .powered_down(powered_down), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // Program word: high part from address bits 10:4, low byte from bits 7:0
    always @(posedge pclk) begin
        prog_word <= {prog_addr[10:4], prog_addr[7:0]};
    end

    task automatic end_of_test;
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rc

    // Issues one instruction, polls status until idle, checks its cycle count
    task automatic ex(input logic [4:0] op, input logic [2:0] b, input logic [6:0] m,
            input logic [10:0] t, input logic [1:0] cyc);
        int n;
        n = 0;
        apb(1'b1, 12'h004, {5'h0, t, 1'b0, m, b, op});
        do begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 8);
        chk("cycles_busy", {29'h0, cyc, 1'b0}, {29'h0, rd[6:5], rd[0]});
    endtask : ex

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end

    initial begin
        logic [32:0] c;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("pc", 12'h010, 32'h0);
        rc("work", 12'h00c, 32'h0);
        rc("table", 12'h014, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, 12'h008, 32'hf);
        chk("status_wr", 32'h1, {31'h0, err});
        apb(1'b1, 12'h240, 32'h0);
        ex(5'h02, 3'h5, 7'h10, 11'h0, 2'h1);
        rc("set", 12'h240, 32'h20);
        apb(1'b1, 12'h240, 32'hff);
        ex(5'h01, 3'h2, 7'h10, 11'h0, 2'h1);
        rc("clr", 12'h240, 32'hfb);
        ex(5'h03, 3'h0, 7'h0, 11'h123, 2'h2);
        rc("pc", 12'h010, 32'h123);
        ex(5'h00, 3'h0, 7'h10, 11'h0, 2'h1);
        rc("pc", 12'h010, 32'h124);
        rc("nop", 12'h240, 32'hfb);
        ex(5'h15, 3'h0, 7'h06, 11'h0, 2'h2);
        for (int i = 0; i < 12; i++) begin
            c = SK[i];
            apb(1'b1, 12'h010, 32'h040);
            apb(1'b1, 12'h00c, 32'haa);
            apb(1'b1, 12'h240, {24'h0, c[24:17]});
            ex(c[32:28], c[27:25], 7'h10, 11'h0, c[0] ? 2'h2 : 2'h1);
            chk("discard", {31'h0, c[0]}, {31'h0, rd[4]});
            rc("mem", 12'h240, {24'h0, c[16:9]});
            rc("work", 12'h00c, {24'h0, c[8:1]});
            rc("pc", 12'h010, c[0] ? 32'h042 : 32'h041);
            ex(5'h03, 3'h0, 7'h0, 11'h100, 2'h2);
            rc("pc", 12'h010, c[0] ? 32'h042 : 32'h100);
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h010, 32'h050);
            ex(5'h0c, 3'h0, 7'h0, 11'h300, 2'h2);
            rc("pc", 12'h010, 32'h300);
            ex(5'h0d + 5'(i), 3'h0, 7'h0, 11'h05a, 2'h2);
            rc("pc", 12'h010, 32'h051);
        end
        rc("work", 12'h00c, 32'h5a);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h2, rd & 32'h2);
        apb(1'b1, 12'h014, 32'h3400);
        apb(1'b1, 12'h010, 32'h512);
        ex(5'h10, 3'h0, 7'h20, 11'h0, 2'h2);
        chk("prog_addr", 32'h534, {21'h0, prog_addr});
        rc("lo", 12'h280, 32'h34);
        rc("hi", 12'h014, 32'h3453);
        ex(5'h11, 3'h0, 7'h20, 11'h0, 2'h2);
        rc("hi", 12'h014, 32'h3473);
        ex(5'h19, 3'h0, 7'h0, 11'h0, 2'h1);
        chk("halt", 32'h3, {30'h0, powered_down, powerdown_flag});
        chk("to", 32'h0, {31'h0, timeout_flag});
        apb(1'b1, 12'h004, 32'h0);
        chk("refuse", 32'h1, {31'h0, err});
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h240, 32'h3c);
        ex(5'h17, 3'h0, 7'h10, 11'h0, 2'h1);
        rc("swap", 12'h240, 32'hc3);
        ex(5'h18, 3'h0, 7'h10, 11'h0, 2'h1);
        rc("swapw", 12'h00c, 32'h3c);
        rc("swapm", 12'h240, 32'hc3);
        ex(5'h16, 3'h0, 7'h10, 11'h0, 2'h1);
        rc("mset", 12'h240, 32'hff);
        ex(5'h13, 3'h0, 7'h0, 11'h0, 2'h1);
        ex(5'h00, 3'h0, 7'h0, 11'h0, 2'h1);
        ex(5'h14, 3'h0, 7'h0, 11'h0, 2'h1);
        chk("pdf", 32'h1, {31'h0, powerdown_flag});
        ex(5'h14, 3'h0, 7'h0, 11'h0, 2'h1);
        ex(5'h13, 3'h0, 7'h0, 11'h0, 2'h1);
        chk("pdf", 32'h0, {31'h0, powerdown_flag});
        ex(5'h19, 3'h0, 7'h0, 11'h0, 2'h1);
        repeat (600) @(posedge pclk);
        chk("wake", 32'h3, {30'h0, timeout_flag, powerdown_flag});
        ex(5'h12, 3'h0, 7'h0, 11'h0, 2'h1);
        chk("wdt", 32'h0, {30'h0, timeout_flag, powerdown_flag});
        end_of_test();
    end
endmodule : bbx_exec_tb
